// [hw/t4hs_top.sv]
// T4 handshake, init source selection and management bit capture with APB registers
//
// Contract
// (RULE_01) Capture management data on management clock rise
// (RULE_02) Station samples device data on clock rise
// (RULE_03) Select goes low when T4 resolved
// (RULE_04) Select high at power-up, negotiating, otherwise
// (RULE_05) Select stays low while auto-negotiation disabled
// (RULE_06) Transceiver drives link-good high on good link
// (RULE_07) Link-good rises 750-1000 ms after select
// (RULE_08) Restart negotiation if link-good never rises
// (RULE_09) Restart negotiation when link-good falls afterwards
// (RULE_10) Parallel detect treats link-good high as ready
// (RULE_11) Forced 100 with link-good: valid, analog off
// (RULE_12) Speed bit clear: link-good ignored entirely
// (RULE_13) Mode pin low/float/high picks init source
// (RULE_14) Strap mode: 10 half sets status, advert
// (RULE_15) Strap mode: 10 full sets status, advert
// (RULE_16) Strap mode: T4 strap sets status, advert
// (RULE_17) EEPROM mode drives the shared clock out
// (RULE_18) Micro mode takes the shared clock in
// (RULE_19) Serial modes shift data from data pin
// (RULE_20) Management clock no faster than 2.5 MHz
// (RULE_21) Init mode latched once until next power-up
// (RULE_22) T4 timeout counted from select falling edge
`timescale 1ns/1ps
`include "t4hs_cfg.svh"
module t4hs_top #(
	parameter int T4_TIMEOUT_CYC = `T4HS_T4_MAX_CYC,
	parameter int INIT_SERIAL_CLOCK_HALF = `T4HS_INIT_SERIAL_CLOCK_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mdc_in,
	input wire logic mdio_in,
	input wire logic mode_sense_pu,
	input wire logic mode_sense_pd,
	input wire logic strap_10_half,
	input wire logic strap_10_full,
	input wire logic strap_t4_capable,
	output logic init_serial_clock_out,
	output logic init_serial_clock_oe_n,
	input wire logic t4_link_good_in,
	output logic t4_select_out,
	input wire logic an_done,
	input wire logic an_hcd_t4,
	input wire logic an_pd_active,
	output logic an_restart,
	output logic t4_link_valid,
	output logic tx_analog_off,
	output logic pd_t4_ready
);
	generate
		if (T4_TIMEOUT_CYC < 2 || T4_TIMEOUT_CYC > 32'h3fffffff) begin : g_chk
			$error("t4hs_top: T4_TIMEOUT_CYC out of range");
		end
	endgenerate

	localparam logic [29:0] TIMEOUT_LAST = 30'(T4_TIMEOUT_CYC - 1);

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	logic [7:0] pins_raw;
	logic [7:0] pins_s;
	logic mdc_s;
	logic mdio_s;
	logic pu_s;
	logic pd_s;
	logic s10h_s;
	logic s10f_s;
	logic st4_s;
	logic lg_s;

	assign pins_raw = {t4_link_good_in, strap_t4_capable, strap_10_full, strap_10_half,
		mode_sense_pd, mode_sense_pu, mdio_in, mdc_in};
	assign {lg_s, st4_s, s10f_s, s10h_s, pd_s, pu_s, mdio_s, mdc_s} = pins_s;

	// Every strap, mode, management and link-good pin passes two flops before any logic reads it
	t4hs_sync #(
		.WIDTH(8)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pins_raw),
		.q(pins_s)
	);

	// ----------------------------------------
	// Initialization source
	// ----------------------------------------
	t4hs_pkg::t4hs_mode_t init_mode;
	logic init_valid;
	logic [2:0] init_caps;
	logic caps_stb;
	logic [15:0] load_data;
	logic [4:0] load_cnt;

	// Micro mode leaves the clock pin undriven and edge-detects it
	t4hs_init #(
		.INIT_SERIAL_CLOCK_HALF(INIT_SERIAL_CLOCK_HALF)
	) u_init (
		.pclk(pclk),
		.presetn(presetn),
		.mode_pu(pu_s),
		.mode_pd(pd_s),
		.strap_10_half(s10h_s),
		.strap_10_full(s10f_s), // see RULE_18
		.strap_t4_capable(st4_s),
		.mode(init_mode),
		.mode_valid(init_valid),
		.caps(init_caps),
		.caps_stb(caps_stb),
		.load_data(load_data),
		.load_cnt(load_cnt),
		.init_serial_clock_out(init_serial_clock_out),
		.init_serial_clock_oe_n(init_serial_clock_oe_n)
	);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic [15:0] ctrl_r;
	logic [15:0] stat_r;
	logic [15:0] adv_r;
	logic timeout_r;
	logic [15:0] mgmt_r;
	logic [7:0] mgmt_cnt_r;
	logic mdc_d_r;
	logic restart_req;
	logic wr_acc;
	logic rd_phase;
	logic to_set;
	logic [31:0] rdata_nxt;
	logic hit;
	t4hs_pkg::t4hs_state_t state_r;
	t4hs_pkg::t4hs_state_t state_nxt;

	// One wait state: data and pready come from flops in the same cycle
	assign rd_phase = psel && penable && !pready;
	assign wr_acc = psel && penable && pready && pwrite;
	assign restart_req = wr_acc && paddr == `T4HS_ADDR_CTRL && pwdata[`T4HS_CTRL_RESTART];

	// Read mux; unmapped addresses read zero and flag an error
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
			`T4HS_ADDR_CTRL: begin
				rdata_nxt = {16'h0000, ctrl_r};
			end
			`T4HS_ADDR_STAT: begin
				rdata_nxt = {16'h0000, stat_r};
			end
			`T4HS_ADDR_ADV: begin
				rdata_nxt = {16'h0000, adv_r};
			end
			`T4HS_ADDR_T4: begin
				rdata_nxt = {21'h000000, state_r, tx_analog_off, t4_link_valid, timeout_r, lg_s,
					t4_select_out, init_valid, init_mode};
			end
			`T4HS_ADDR_MGMT: begin
				rdata_nxt = {8'h00, mgmt_cnt_r, mgmt_r};
			end
			`T4HS_ADDR_INIT: begin
				rdata_nxt = {11'h000, 5'(load_cnt), load_data};
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Answer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= rd_phase;
			pslverr <= rd_phase && !hit;
			prdata <= (rd_phase && !pwrite) ? rdata_nxt : 32'h0000_0000;
		end
	end

	// Control register; the restart bit is a self-clearing command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= `T4HS_CTRL_RST;
		else if (wr_acc && paddr == `T4HS_ADDR_CTRL)
			ctrl_r <= pwdata[15:0] & ~(16'h0001 << `T4HS_CTRL_RESTART);
	end

	// Capability status follows straps in strap mode, else the loaded word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 16'h0000;
		end else if (caps_stb) begin
			stat_r[`T4HS_STAT_10HD] <= init_caps[0]; // see RULE_14
			stat_r[`T4HS_STAT_10FD] <= init_caps[1]; // see RULE_15
			stat_r[`T4HS_STAT_T4] <= init_caps[2]; // see RULE_16
		end
	end

	// Advertisement defaults load at capture; software may override later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adv_r <= 16'h0000;
		end else if (caps_stb) begin
			adv_r[`T4HS_ADV_10HD] <= init_caps[0]; // see RULE_14
			adv_r[`T4HS_ADV_10FD] <= init_caps[1]; // see RULE_15
			adv_r[`T4HS_ADV_T4] <= init_caps[2]; // see RULE_16
		end else if (wr_acc && paddr == `T4HS_ADDR_ADV) begin
			adv_r <= pwdata[15:0];
		end
	end

	// Timeout flag: a new timeout beats a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timeout_r <= 1'b0;
		else if (to_set)
			timeout_r <= 1'b1;
		else if (wr_acc && paddr == `T4HS_ADDR_T4 && pwdata[`T4HS_T4_TIMEOUT])
			timeout_r <= 1'b0;
	end

	// ----------------------------------------
	// Management data capture
	// ----------------------------------------
	// Bits shift in on each synchronised management clock rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc_d_r <= 1'b0;
			mgmt_r <= 16'h0000;
			mgmt_cnt_r <= 8'h00;
		end else begin
			mdc_d_r <= mdc_s;
			if (mdc_s && !mdc_d_r) begin
				mgmt_r <= {mgmt_r[14:0], mdio_s}; // see RULE_01
				mgmt_cnt_r <= mgmt_cnt_r + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// T4 handshake sequencer
	// ----------------------------------------
	logic an_en;
	logic speed100;
	logic lg;
	logic t4_ok;
	logic [29:0] t4_cnt_r;

	assign an_en = ctrl_r[`T4HS_CTRL_ANEN];
	assign speed100 = ctrl_r[`T4HS_CTRL_SPEED];
	assign lg = lg_s && speed100; // see RULE_12
	assign t4_ok = stat_r[`T4HS_STAT_T4];
	assign to_set = state_r == t4hs_pkg::ST_T4_WAIT && !lg && t4_cnt_r == TIMEOUT_LAST;

	// Next state; a forced link leaves negotiation entirely
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			t4hs_pkg::ST_POWERUP: begin
				if (init_valid)
					state_nxt = an_en ? t4hs_pkg::ST_NEGOTIATE : t4hs_pkg::ST_FORCED;
			end
			t4hs_pkg::ST_NEGOTIATE: begin
				if (an_done)
					state_nxt = (an_hcd_t4 && t4_ok) ? t4hs_pkg::ST_T4_WAIT : t4hs_pkg::ST_OTHER; // see RULE_03
			end
			t4hs_pkg::ST_T4_WAIT: begin
				if (lg)
					state_nxt = t4hs_pkg::ST_T4_UP;
				else if (to_set)
					state_nxt = t4hs_pkg::ST_NEGOTIATE; // see RULE_08
			end
			t4hs_pkg::ST_T4_UP: begin
				if (!lg)
					state_nxt = t4hs_pkg::ST_NEGOTIATE; // see RULE_09
			end
			t4hs_pkg::ST_OTHER: begin
				if (!an_done)
					state_nxt = t4hs_pkg::ST_NEGOTIATE;
			end
			t4hs_pkg::ST_FORCED: begin
				if (an_en)
					state_nxt = t4hs_pkg::ST_NEGOTIATE;
			end
			default: begin
				state_nxt = t4hs_pkg::ST_POWERUP;
			end
		endcase
		if (state_r != t4hs_pkg::ST_POWERUP) begin
			if (!an_en)
				state_nxt = t4hs_pkg::ST_FORCED;
			else if (restart_req)
				state_nxt = t4hs_pkg::ST_NEGOTIATE;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_r <= t4hs_pkg::ST_POWERUP;
		else
			state_r <= state_nxt;
	end

	// Select is low only while T4 is chosen or negotiation is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t4_select_out <= 1'b1; // see RULE_04
		else
			t4_select_out <= !(state_nxt == t4hs_pkg::ST_T4_WAIT || state_nxt == t4hs_pkg::ST_T4_UP
				|| state_nxt == t4hs_pkg::ST_FORCED); // see RULE_03, see RULE_04, see RULE_05
	end

	// Timeout counter starts with the cycle select goes low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t4_cnt_r <= 30'h0000_0000;
		else if (state_r != t4hs_pkg::ST_T4_WAIT)
			t4_cnt_r <= 30'h0000_0000; // see RULE_22
		else if (t4_cnt_r != TIMEOUT_LAST)
			t4_cnt_r <= t4_cnt_r + 30'h0000_0001; // see RULE_22
	end

	// Restart pulse for the negotiation engine: software, timeout, lost link, or a return to negotiation from ST_OTHER or ST_FORCED
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			an_restart <= 1'b0;
		else
			an_restart <= state_r != t4hs_pkg::ST_POWERUP && state_nxt == t4hs_pkg::ST_NEGOTIATE
				&& (state_r != t4hs_pkg::ST_NEGOTIATE || restart_req); // see RULE_08, see RULE_09
	end

	// Forced 100 Mb/s: a good T4 link wins over the TX analog path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t4_link_valid <= 1'b0;
			tx_analog_off <= 1'b0;
			pd_t4_ready <= 1'b0;
		end else begin
			t4_link_valid <= state_nxt == t4hs_pkg::ST_T4_UP || (!an_en && lg); // see RULE_11
			tx_analog_off <= !an_en && lg && state_r == t4hs_pkg::ST_FORCED; // see RULE_11
			pd_t4_ready <= an_en && an_pd_active && lg; // see RULE_10
		end
	end
endmodule

// [hw/t4hs_cfg.svh]
// Offsets, field positions, reset values and timing counts for the T4 handshake block
`ifndef T4HS_CFG_SVH
`define T4HS_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define T4HS_CLK_HZ 40000000
`define T4HS_CLK_NS 25
`define T4HS_T4_MAX_MS 1000
`define T4HS_T4_MAX_CYC (`T4HS_T4_MAX_MS * (`T4HS_CLK_HZ / 1000))
`define T4HS_SETTLE_NS 1000
`define T4HS_SETTLE_CYC ((`T4HS_SETTLE_NS + `T4HS_CLK_NS - 1) / `T4HS_CLK_NS)
`define T4HS_INIT_SERIAL_CLOCK_HALF_NS 500
`define T4HS_INIT_SERIAL_CLOCK_HALF_CYC (`T4HS_INIT_SERIAL_CLOCK_HALF_NS / `T4HS_CLK_NS)
`define T4HS_LOAD_BITS 16

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define T4HS_ADDR_CTRL 8'h00
`define T4HS_ADDR_STAT 8'h04
`define T4HS_ADDR_ADV 8'h08
`define T4HS_ADDR_T4 8'h0c
`define T4HS_ADDR_MGMT 8'h10
`define T4HS_ADDR_INIT 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define T4HS_CTRL_SPEED 13
`define T4HS_CTRL_ANEN 12
`define T4HS_CTRL_RESTART 9
`define T4HS_CTRL_RST 16'h3000
`define T4HS_STAT_T4 15
`define T4HS_STAT_10FD 12
`define T4HS_STAT_10HD 11
`define T4HS_ADV_T4 9
`define T4HS_ADV_10FD 6
`define T4HS_ADV_10HD 5
`define T4HS_T4_TIMEOUT 5

`endif

// [hw/t4hs_pkg.sv]
// Types shared by the T4 handshake block
package t4hs_pkg;
	// Initialization source picked at power-up
	typedef enum logic [1:0] {MODE_STRAP, MODE_EEPROM, MODE_MCU} t4hs_mode_t;
	// Handshake sequencer states
	typedef enum logic [2:0] {
		ST_POWERUP, ST_NEGOTIATE, ST_T4_WAIT, ST_T4_UP, ST_OTHER, ST_FORCED
	} t4hs_state_t;
endpackage

// [hw/t4hs_sync.sv]
// Two-stage synchroniser for pins from outside the pclk domain
`timescale 1ns/1ps
module t4hs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	generate
		if (WIDTH < 1) begin : g_chk
			$error("t4hs_sync: WIDTH must be at least 1");
		end
	endgenerate

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// [hw/t4hs_init.sv]
// Power-up mode capture, strap capture and serial initialization loader
`timescale 1ns/1ps
`include "t4hs_cfg.svh"
module t4hs_init #(
	parameter int INIT_SERIAL_CLOCK_HALF = `T4HS_INIT_SERIAL_CLOCK_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mode_pu,
	input wire logic mode_pd,
	input wire logic strap_10_half,
	input wire logic strap_10_full,
	input wire logic strap_t4_capable,
	output t4hs_pkg::t4hs_mode_t mode,
	output logic mode_valid,
	output logic [2:0] caps,
	output logic caps_stb,
	output logic [15:0] load_data,
	output logic [4:0] load_cnt,
	output logic init_serial_clock_out,
	output logic init_serial_clock_oe_n
);
	generate
		if (INIT_SERIAL_CLOCK_HALF < 1 || INIT_SERIAL_CLOCK_HALF > 255) begin : g_chk
			$error("t4hs_init: INIT_SERIAL_CLOCK_HALF out of range");
		end
	endgenerate

	localparam logic [7:0] SETTLE = 8'(`T4HS_SETTLE_CYC);
	localparam logic [7:0] HALF = 8'(INIT_SERIAL_CLOCK_HALF - 1);
	localparam logic [4:0] NBITS = 5'(`T4HS_LOAD_BITS);

	logic [7:0] settle_r;
	logic [7:0] div_r;
	logic clk_pin_d_r;
	logic eeprom;
	logic mcu;
	logic rise;
	logic [15:0] data_nxt;

	assign eeprom = mode_valid && mode == t4hs_pkg::MODE_EEPROM;
	assign mcu = mode_valid && mode == t4hs_pkg::MODE_MCU;
	// Own clock rises at end of its low half; the micro's clock by edge detect
	assign rise = eeprom ? (div_r == HALF && !init_serial_clock_out) : (mcu && strap_10_full && !clk_pin_d_r);
	assign data_nxt = {load_data[14:0], strap_t4_capable};

	// ----------------------------------------
	// Mode capture
	// ----------------------------------------
	// Let the mode pin settle after reset, then latch it once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_r <= 8'h00;
			mode_valid <= 1'b0;
			mode <= t4hs_pkg::MODE_STRAP;
		end else if (!mode_valid) begin
			settle_r <= settle_r + 8'h01;
			if (settle_r == SETTLE) begin
				mode_valid <= 1'b1; // see RULE_21
				if (!mode_pu)
					mode <= t4hs_pkg::MODE_STRAP; // see RULE_13
				else if (mode_pd)
					mode <= t4hs_pkg::MODE_MCU; // see RULE_13
				else
					mode <= t4hs_pkg::MODE_EEPROM; // see RULE_13
			end
		end
	end

	// ----------------------------------------
	// Serial clock and loader
	// ----------------------------------------
	// Clock driven only in EEPROM mode; stops low once the word is in, so the last high phase is never cut short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 8'h00;
			init_serial_clock_out <= 1'b0;
			init_serial_clock_oe_n <= 1'b1;
		end else begin
			init_serial_clock_oe_n <= !eeprom; // see RULE_17
			if (eeprom && (load_cnt != NBITS || init_serial_clock_out)) begin
				div_r <= (div_r == HALF) ? 8'h00 : div_r + 8'h01;
				if (div_r == HALF)
					init_serial_clock_out <= !init_serial_clock_out; // see RULE_17
			end else begin
				init_serial_clock_out <= 1'b0;
			end
		end
	end

	// Shift data in on each rising init clock, MSB first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_pin_d_r <= 1'b0;
			load_data <= 16'h0000;
			load_cnt <= 5'h00;
		end else begin
			clk_pin_d_r <= strap_10_full;
			if (rise && load_cnt != NBITS) begin
				load_data <= data_nxt; // see RULE_19
				load_cnt <= load_cnt + 5'h01;
			end
		end
	end

	// Capability bits come from straps, or from the loaded word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			caps <= 3'h0;
			caps_stb <= 1'b0;
		end else begin
			caps_stb <= 1'b0;
			if (!mode_valid && settle_r == SETTLE && !mode_pu) begin
				caps <= {strap_t4_capable, strap_10_full, strap_10_half}; // see RULE_14
				caps_stb <= 1'b1;
			end else if (rise && load_cnt == NBITS - 5'h01) begin
				caps <= {data_nxt[15], data_nxt[12], data_nxt[11]};
				caps_stb <= 1'b1;
			end
		end
	end
endmodule

// [tb/t4hs_top_chk.sv]
// Concurrent checks on the T4 handshake top-level ports
`timescale 1ns/1ps
module t4hs_top_chk #(
	parameter int T4_TIMEOUT_CYC = 200
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic t4_link_good_in,
	input wire logic t4_select_out,
	input wire logic an_done,
	input wire logic an_hcd_t4,
	input wire logic an_pd_active,
	input wire logic an_restart,
	input wire logic t4_link_valid,
	input wire logic tx_analog_off,
	input wire logic pd_t4_ready,
	input wire logic init_serial_clock_out
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic [31:0] wait_cnt_r;
	// Cycles spent with T4 selected and no valid link; a counter avoids a huge unrolled repetition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt_r <= 32'h0;
		end else if (!t4_select_out && an_done && !t4_link_valid) begin
			wait_cnt_r <= wait_cnt_r + 32'h1;
		end else begin
			wait_cnt_r <= 32'h0;
		end
	end
	// ----------------------------------------
	// Sequences and assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_other_done; $rose(an_done) && !an_hcd_t4 && t4_select_out; endsequence
	sequence s_pd_good; (an_pd_active && t4_link_good_in) [*5]; endsequence
	sequence s_link_drop; $fell(t4_link_good_in) && t4_link_valid && an_done; endsequence
	a_sel_reset_high: assert property ($rose(presetn) |-> t4_select_out)
		else $error("select not high after reset");
	a_sel_other_high: assert property (s_other_done |=> t4_select_out [*3])
		else $error("select fell for a non T4 result");
	a_t4_wait_bound: assert property (wait_cnt_r <= T4_TIMEOUT_CYC + 4)
		else $error("T4 wait ran past the timeout");
	a_restart_deselect: assert property (an_restart |-> ##[0:2] t4_select_out)
		else $error("select stayed low across a restart");
	a_drop_restart: assert property (s_link_drop |-> ##[1:6] an_restart)
		else $error("no restart after link loss");
	a_pd_ready_up: assert property (s_pd_good |-> pd_t4_ready)
		else $error("parallel detect missed a good T4 link");
	a_forced_analog: assert property (tx_analog_off |-> !t4_select_out)
		else $error("analog off outside forced T4 operation");
	a_init_serial_clock_half_min: assert property ($rose(init_serial_clock_out) |=> $stable(init_serial_clock_out) [*8])
		else $error("init clock high phase too short");
	a_apb_one_wait: assert property (s_access |=> pready)
		else $error("access not answered after one wait state");
	a_apb_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_apb_err_ready: assert property (pslverr |-> pready)
		else $error("error flagged without ready");
endmodule

// [tb/t4hs_t4_model.sv]
// Behavioural external T4 transceiver on the select and link-good pins
`timescale 1ns/1ps
module t4hs_t4_model (
	input wire logic pclk,
	input wire logic t4_select_out,
	input wire logic answer_en,
	input wire logic link_on,
	input wire logic drop,
	input wire logic [15:0] delay_cyc,
	output logic t4_link_good_in
);
	logic [15:0] cnt = 16'h0;
	// Link rises a set time after select falls and goes down at once when deselected or dropped
	always @(posedge pclk) begin
		if (t4_select_out || drop)
			cnt <= 16'h0;
		else if (cnt != 16'hffff)
			cnt <= cnt + 16'h1;
		t4_link_good_in <= link_on || (answer_en && !drop && !t4_select_out && cnt >= delay_cyc);
	end
endmodule

// [tb/t4hs_top_tb.sv]
// Self-checking bench for the T4 handshake block
`timescale 1ns/1ps
`include "t4hs_cfg.svh"
module t4hs_top_tb;
	localparam int T4_CYC = 200;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata, restart_cnt = 32'h0;
	logic pready, pslverr, rerr, mdc_in = 1'b0, mdio_in = 1'b0, mode_sense_pu = 1'b0, mode_sense_pd = 1'b0;
	logic strap_10_half = 1'b1, strap_10_full = 1'b0, strap_t4_capable = 1'b1;
	logic init_serial_clock_out, init_serial_clock_oe_n, t4_link_good_in, t4_select_out;
	logic an_done = 1'b0, an_hcd_t4 = 1'b0, an_pd_active = 1'b0, an_restart;
	logic t4_link_valid, tx_analog_off, pd_t4_ready, answer_en = 1'b0, link_on = 1'b0, drop = 1'b0;
	logic [15:0] delay_cyc = 16'h000a;
	int num_errors = 0, samples_checked = 0;
	// ----------------------------------------
	// Clock, design and partner
	// ----------------------------------------
	always #12.5 pclk = ~pclk;
	t4hs_top #(.T4_TIMEOUT_CYC(T4_CYC), .INIT_SERIAL_CLOCK_HALF(20)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mdc_in(mdc_in), .mdio_in(mdio_in), .mode_sense_pu(mode_sense_pu),
		.mode_sense_pd(mode_sense_pd), .strap_10_half(strap_10_half), .strap_10_full(strap_10_full),
		.strap_t4_capable(strap_t4_capable), .init_serial_clock_out(init_serial_clock_out),
		.init_serial_clock_oe_n(init_serial_clock_oe_n), .t4_link_good_in(t4_link_good_in),
		.t4_select_out(t4_select_out), .an_done(an_done), .an_hcd_t4(an_hcd_t4), .an_pd_active(an_pd_active),
		.an_restart(an_restart), .t4_link_valid(t4_link_valid), .tx_analog_off(tx_analog_off),
		.pd_t4_ready(pd_t4_ready));
	t4hs_t4_model i_t4 (.pclk(pclk), .t4_select_out(t4_select_out), .answer_en(answer_en), .link_on(link_on),
		.drop(drop), .delay_cyc(delay_cyc), .t4_link_good_in(t4_link_good_in));
	// Restart pulses counted independently of the design
	always @(posedge pclk) begin
		if (an_restart === 1'b1)
			restart_cnt <= restart_cnt + 32'h1;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task give_verdict;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until ready is seen high at a rising edge
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			give_verdict;
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rst(input logic pu, input logic pd);
		mode_sense_pu <= pu;
		mode_sense_pd <= pd;
		presetn <= 1'b0;
		cyc(10);
		presetn <= 1'b1;
		cyc(2);
		chk(32'(t4_select_out), 32'h1);
		cyc(50);
	endtask
	// Serial word MSB first, data set mid low phase; management or init pins
	task shift(input logic [15:0] w, input int half, input logic mgmt);
		for (int i = 15; i >= 0; i--) begin
			if (mgmt)
				mdio_in <= w[i];
			else
				strap_t4_capable <= w[i];
			cyc(half / 2);
			if (mgmt)
				mdc_in <= 1'b1;
			else
				strap_10_full <= 1'b1;
			cyc(half);
			if (mgmt)
				mdc_in <= 1'b0;
			else
				strap_10_full <= 1'b0;
			cyc(half / 2);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		rst(1'b0, 1'b0);
		apb(`T4HS_ADDR_CTRL, 1'b0, 32'h0);
		chk(rdata, 32'h3000);
		apb(`T4HS_ADDR_STAT, 1'b0, 32'h0);
		chk(rdata, 32'h8800);
		apb(`T4HS_ADDR_ADV, 1'b0, 32'h0);
		chk(rdata & 32'h260, 32'h220);
		apb(`T4HS_ADDR_T4, 1'b0, 32'h0);
		chk(rdata & 32'h7, 32'h4);
		apb(8'h40, 1'b1, 32'hffff_ffff);
		apb(8'h40, 1'b0, 32'h0);
		chk({rdata[30:0], rerr}, 32'h1);
		apb(`T4HS_ADDR_ADV, 1'b1, 32'h40);
		apb(`T4HS_ADDR_ADV, 1'b0, 32'h0);
		chk(rdata & 32'h260, 32'h40);
		// Management clock at 2.5 MHz, 16 cycles per period
		shift(16'h5ab4, 8, 1'b1);
		apb(`T4HS_ADDR_MGMT, 1'b0, 32'h0);
		chk(rdata & 32'hff_ffff, 32'h10_5ab4);
		// Parallel detection with the transceiver reporting link on its own
		an_pd_active <= 1'b1;
		link_on <= 1'b1;
		cyc(8);
		chk(32'(pd_t4_ready), 32'h1);
		link_on <= 1'b0;
		an_pd_active <= 1'b0;
		cyc(8);
		// Slow answer late in the window, then link loss
		answer_en <= 1'b1;
		delay_cyc <= 16'd150;
		an_hcd_t4 <= 1'b1;
		an_done <= 1'b1;
		cyc(4);
		chk(32'(t4_select_out), 32'h0);
		cyc(160);
		chk(32'(t4_link_valid), 32'h1);
		chk(restart_cnt, 32'h0);
		apb(`T4HS_ADDR_T4, 1'b0, 32'h0);
		chk(rdata & 32'h710, 32'h310);
		drop <= 1'b1;
		cyc(3);
		an_done <= 1'b0; // Engine leaves done as negotiation restarts
		cyc(5);
		chk(restart_cnt, 32'h1);
		chk(32'(t4_select_out), 32'h1);
		drop <= 1'b0;
		an_done <= 1'b0;
		cyc(4);
		// No answer: restart after the timeout, sticky flag cleared by writing one
		answer_en <= 1'b0;
		an_done <= 1'b1;
		cyc(4);
		chk(32'(t4_select_out), 32'h0);
		cyc(T4_CYC - 20);
		an_done <= 1'b0;
		cyc(30);
		chk(restart_cnt, 32'h2);
		apb(`T4HS_ADDR_T4, 1'b0, 32'h0);
		chk(rdata & 32'h28, 32'h28);
		apb(`T4HS_ADDR_T4, 1'b1, 32'h20);
		apb(`T4HS_ADDR_T4, 1'b0, 32'h0);
		chk(rdata & 32'h20, 32'h0);
		// Another technology resolved
		an_done <= 1'b0;
		an_hcd_t4 <= 1'b0;
		cyc(4);
		an_done <= 1'b1;
		cyc(6);
		chk(32'(t4_select_out), 32'h1);
		// Software restart pulses once and the command bit reads back clear
		apb(`T4HS_ADDR_CTRL, 1'b1, 32'h3200);
		cyc(2);
		chk(restart_cnt, 32'h3);
		apb(`T4HS_ADDR_CTRL, 1'b0, 32'h0);
		chk(rdata, 32'h3000);
		an_done <= 1'b0;
		// Negotiation disabled, 100 Mb/s forced, then speed bit cleared
		answer_en <= 1'b1;
		delay_cyc <= 16'd10;
		apb(`T4HS_ADDR_CTRL, 1'b1, 32'h2000);
		cyc(3);
		chk(32'(t4_select_out), 32'h0);
		cyc(20);
		chk({30'h0, tx_analog_off, t4_link_valid}, 32'h3);
		apb(`T4HS_ADDR_CTRL, 1'b1, 32'h0);
		cyc(6);
		chk({30'h0, tx_analog_off, t4_link_valid}, 32'h0);
		chk(32'(t4_select_out), 32'h0);
		// EEPROM mode: device clock out, mode kept when the pin moves
		rst(1'b1, 1'b0);
		chk(32'(init_serial_clock_oe_n), 32'h0);
		mode_sense_pu <= 1'b0;
		cyc(4);
		apb(`T4HS_ADDR_T4, 1'b0, 32'h0);
		chk(rdata & 32'h7, 32'h5);
		cyc(700);
		apb(`T4HS_ADDR_INIT, 1'b0, 32'h0);
		chk(rdata & 32'h1f_ffff, 32'h10_ffff);
		// Microcontroller mode: clock in at 200 ns, strap levels ignored
		rst(1'b1, 1'b1);
		chk(32'(init_serial_clock_oe_n), 32'h1);
		shift(16'h9001, 4, 1'b0);
		cyc(10);
		apb(`T4HS_ADDR_INIT, 1'b0, 32'h0);
		chk(rdata & 32'h1f_ffff, 32'h10_9001);
		apb(`T4HS_ADDR_T4, 1'b0, 32'h0);
		chk(rdata & 32'h7, 32'h6);
		apb(`T4HS_ADDR_STAT, 1'b0, 32'h0);
		chk(rdata, 32'h9000);
		give_verdict;
	end
endmodule
bind t4hs_top t4hs_top_chk #(.T4_TIMEOUT_CYC(T4_TIMEOUT_CYC)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .t4_link_good_in(t4_link_good_in),
	.t4_select_out(t4_select_out), .an_done(an_done), .an_hcd_t4(an_hcd_t4), .an_pd_active(an_pd_active),
	.an_restart(an_restart), .t4_link_valid(t4_link_valid), .tx_analog_off(tx_analog_off),
	.pd_t4_ready(pd_t4_ready), .init_serial_clock_out(init_serial_clock_out));
